//--- cra_pkg.sv
// Shared constants, types and helpers for the clock rate adapter and reference block
package cra_pkg;
	localparam int NPORT = 4;
	localparam int NRATE = 3;
	localparam logic [1:0] RATE_DS3 = 2'h0;
	localparam logic [1:0] RATE_E3 = 2'h1;
	localparam logic [1:0] RATE_STS1 = 2'h2;
	localparam logic [2:0] ALL_RATES = 3'h7;
	localparam logic [1:0] RATE_CODE_OFS = 2'h1;
	localparam logic [1:0] MODE_BYPASS = 2'h0;
	localparam logic [1:0] OUT_NONE = 2'h0;
	localparam logic [1:0] OUT_B = 2'h1;
	localparam logic [1:0] OUT_C = 2'h2;
	localparam logic [1:0] OUT_BOTH = 2'h3;
	localparam logic [2:0] GSRC_OFF = 3'h0;
	localparam int GSRC_PORT_BIT = 2;
	localparam logic [1:0] PSRC_TXFR = 2'h3;
	localparam int PSRC_DIV_BIT = 1;
	localparam int FM_RATE_HI = 5;
	localparam int FM_RATE_LO = 4;
	localparam int LM_LIU_EN = 0;
	localparam int SY_A = 0;
	localparam int SY_G4 = 3;
	localparam int SY_TX = 4;
	localparam int SY_RX = 8;
	localparam int SY_N = 12;
	localparam int DIV_W = 13;
	localparam logic [12:0] DIV_STS1 = 13'h1950;
	localparam logic [12:0] DIV_DS3 = 13'h15D8;
	localparam logic [12:0] DIV_E3 = 13'h10C8;
	localparam logic [12:0] DIV_SEC = 13'h1F40;
	// Rates in kHz, used to derive the synthesiser increments and in the bench rate checks
	localparam longint KHZ_DS3 = 64'h0000_0000_0000_AEC0;
	localparam longint KHZ_E3 = 64'h0000_0000_0000_8640;
	localparam longint KHZ_STS1 = 64'h0000_0000_0000_CA80;
	localparam longint ACC_ONE = 64'h0000_0000_0000_8000;
	localparam logic [17:0] ACC_UNIT = 18'(ACC_ONE);
	// Increment per source edge, [source][target], fraction of ACC_UNIT
	localparam logic [17:0] PLL_INC [3][3] = '{
		'{ACC_UNIT, 18'((KHZ_E3 * ACC_ONE) / KHZ_DS3), 18'((KHZ_STS1 * ACC_ONE) / KHZ_DS3)},
		'{18'((KHZ_DS3 * ACC_ONE) / KHZ_E3), ACC_UNIT, 18'((KHZ_STS1 * ACC_ONE) / KHZ_E3)},
		'{18'((KHZ_DS3 * ACC_ONE) / KHZ_STS1), 18'((KHZ_E3 * ACC_ONE) / KHZ_STS1), ACC_UNIT}
	};

	typedef struct packed {
		logic [3:0] rate_adapter_mode;
		logic ext_ref_input_select;
		logic ref_output_select;
		logic [2:0] global_ref_source;
	} cra_glob_cfg_s;

	typedef struct packed {
		logic [5:0] framing_mode_bits;
		logic [2:0] line_mode_bits;
		logic tx_clock_from_adapter;
		logic [1:0] port_ref_source;
		logic tx_plcp_ref_select;
	} cra_port_cfg_s;

	function automatic logic [1:0] fm_rate(input logic [5:0] fm);
		case (fm[FM_RATE_HI:FM_RATE_LO])
			2'h0: fm_rate = RATE_DS3;
			2'h1: fm_rate = RATE_E3;
			default: fm_rate = RATE_STS1;
		endcase
	endfunction

	function automatic logic [12:0] rate_div(input logic [1:0] r);
		case (r)
			RATE_DS3: rate_div = DIV_DS3;
			RATE_E3: rate_div = DIV_E3;
			default: rate_div = DIV_STS1;
		endcase
	endfunction
endpackage

//--- cra_divider.sv
// Tick divider producing a half-duty level and a rise pulse
`timescale 1ns/1ns
`default_nettype none
module cra_divider (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic restart, // Clear count on source change
	input wire logic enable, // Divider powered
	input wire logic tick, // Source edge event
	input wire logic [12:0] divisor, // Ticks per output period
	output logic level, // Output level, low first half
	output logic rise // One-cycle pulse at level rise
);
	logic [12:0] cnt_q;
	logic [12:0] cnt_d;
	logic [12:0] half;
	logic level_q;
	logic rise_q;
	logic [12:0] ticks_q;
	logic seen_q;

	assign half = divisor >> 1;
	assign level = level_q;
	assign rise = rise_q;

	always_comb begin
		cnt_d = cnt_q;
		if (tick) begin
			cnt_d = (cnt_q == divisor - 13'h0001) ? 13'h0000 : cnt_q + 13'h0001;
		end
	end

	// Starts from zero, so the first rise only comes after half a full period
	always_ff @(posedge ref_clk) begin
		if (rst || restart || !enable) begin
			cnt_q <= 13'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || restart || !enable) begin
			level_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			level_q <= (cnt_d >= half);
			rise_q <= tick && (cnt_q == half - 13'h0001);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || restart || !enable) begin
			ticks_q <= 13'h0000;
			seen_q <= 1'b0;
		end else if (rise_q) begin
			ticks_q <= {12'h000, tick};
			seen_q <= 1'b1;
		end else if (tick) begin
			ticks_q <= ticks_q + 13'h0001;
		end
	end

	a_rise_spacing: assert property (@(posedge ref_clk) disable iff (rst || restart || !enable)
		(rise_q && seen_q) |-> (ticks_q == divisor))
		else $error("Divider rise spacing differs from divisor");
endmodule
`default_nettype wire

//--- cra_clock_ref.sv
// Clock rate adapter, 8 kHz reference selection and one-second reference
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Mode 00XX: synthesisers off, all three clock pins are reference inputs.
// - Upper mode bits name the pin A rate: 01 DS3, 10 E3, 11 STS-1.
// - Lower bits 00 drive B and C low; 01 first rate on B; 10 other on C.
// - Lower bits 11 output both remaining rates, per fixed pin mapping.
// - Synthesise missing standard rates from the supplied one in synthesiser modes.
// - Power down any synthesiser whose rate nobody needs.
// - Each line interface reference follows the port framing mode rate.
// - Transmit clock comes from adapter rate when the port asks for it.
// - External select takes global 8 kHz from general pin four.
// - Output select drives global 8 kHz onto general pin two.
// - Global source field: off, adapter rates or pins, or ports one to four.
// - Divide 51.84 MHz by 6480, DS3 by 5592, E3 by 4296.
// - Port divisor follows port rate; global divisor follows chosen adapter rate.
// - Port 8 kHz source chosen from three sources by a 2-bit field.
// - Port field: 0X receive PLCP, 10 receive clock, 11 transmit clock.
// - Per-port bit picks global or own 8 kHz for transmit PLCP.
// - Transmit PLCP framing is paced by the 8 kHz reference.
// - One-second reference is global 8 kHz divided by 8000.
// - Half-duty one-second level; its rise sets a latched flag.
// - After reset adapter, 8 kHz and one-second timers are disabled.
// - At reset the three adapter pins are reference inputs.
// - Deselected 8 kHz source or disabled adapter powers those circuits down.
module cra_clock_ref (
	input wire logic ref_clk, // 20 MHz system clock
	input wire logic rst, // Synchronous reset, active high
	input wire cra_pkg::cra_glob_cfg_s glob_cfg, // Global configuration bits
	input wire cra_pkg::cra_port_cfg_s [3:0] port_cfg, // Per-port configuration bits
	input wire logic primary_ref_pin_i, // Pin A level
	input wire logic second_ref_pin_i, // Pin B level
	output logic second_ref_pin_o, // Pin B drive level
	output logic second_ref_pin_oe, // Pin B driven
	input wire logic third_ref_pin_i, // Pin C level
	output logic third_ref_pin_o, // Pin C drive level
	output logic third_ref_pin_oe, // Pin C driven
	input wire logic [3:0] tx_clk_pin, // Port transmit clock pins
	input wire logic [3:0] rx_line_clk, // Port receive line clocks
	input wire logic [3:0] rx_plcp_8k, // Receive PLCP 8 kHz pulses
	input wire logic general_pin_four_i, // External 8 kHz input
	output logic general_pin_two_o, // Global 8 kHz out
	output logic general_pin_two_oe, // Pin two driven
	input wire logic second_flag_clear, // Clear latched second flag
	output logic [2:0] pll_enable, // Synthesiser enables DS3, E3, STS-1
	output logic [3:0] liu_ref_tick, // Line interface reference edges
	output logic [3:0] tx_clk_tick, // Transmit clock edges
	output logic [3:0] tx_plcp_frame_ref, // Transmit PLCP frame pulses
	output logic frame_ref_8khz, // Global 8 kHz pulse
	output logic one_second_ref, // One-second level
	output logic latched_second_flag // Latched one-second flag
);
	cra_pkg::cra_glob_cfg_s gcfg_q;
	cra_pkg::cra_port_cfg_s [3:0] pcfg_q;
	logic [cra_pkg::SY_N-1:0] async_in;
	logic [cra_pkg::SY_N-1:0] sy1_q;
	logic [cra_pkg::SY_N-1:0] sy2_q;
	logic [cra_pkg::SY_N-1:0] sy3_q;
	logic [cra_pkg::SY_N-1:0] pin_edge;
	logic pll_mode;
	logic [1:0] src;
	logic [1:0] out_sel;
	logic [1:0] first_r;
	logic [1:0] other_r;
	logic [1:0] b_rate;
	logic [1:0] c_rate;
	logic b_on;
	logic c_on;
	logic [2:0] pll_need;
	logic [2:0] pll_en_d;
	logic [2:0] pll_en_q;
	logic [2:0] gen;
	logic [2:0] tog_q;
	logic [2:0] rate_tick;
	logic [17:0] acc_q [3];
	logic [3:0][1:0] port_rate;
	logic [3:0] tx_pick;
	logic [3:0] port8k;
	logic [3:0] port_chg;
	logic [3:0] liu_q;
	logic [3:0] txc_q;
	logic [3:0] plcp_q;
	logic pin_b_q;
	logic pin_c_q;
	logic g_chg;
	logic g_adapt;
	logic g_en;
	logic [1:0] g_rate;
	logic g_rise;
	logic g8k_d;
	logic g8k_q;
	logic pin2_q;
	logic sec_rise;
	logic flag_q;

	// Configuration defaults to everything off
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gcfg_q <= '0;
			pcfg_q <= '0;
		end else begin
			gcfg_q <= glob_cfg;
			pcfg_q <= port_cfg;
		end
	end

	assign async_in = {rx_line_clk, tx_clk_pin, general_pin_four_i, third_ref_pin_i,
		second_ref_pin_i, primary_ref_pin_i};

	// Sampling the reference pins at 20 MHz only resolves edge events, not true rate
	for (genvar i = 0; i < cra_pkg::SY_N; i++) begin : g_sync
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				sy1_q[i] <= 1'b0;
				sy2_q[i] <= 1'b0;
				sy3_q[i] <= 1'b0;
			end else begin
				sy1_q[i] <= async_in[i];
				sy2_q[i] <= sy1_q[i];
				sy3_q[i] <= sy2_q[i];
			end
		end
		assign pin_edge[i] = sy2_q[i] && !sy3_q[i];
	end

	assign pll_mode = gcfg_q.rate_adapter_mode[3:2] != cra_pkg::MODE_BYPASS;
	assign src = gcfg_q.rate_adapter_mode[3:2] - cra_pkg::RATE_CODE_OFS;
	assign out_sel = gcfg_q.rate_adapter_mode[1:0];
	assign first_r = (src == cra_pkg::RATE_E3) ? cra_pkg::RATE_DS3 : cra_pkg::RATE_E3;
	assign other_r = (src == cra_pkg::RATE_STS1) ? cra_pkg::RATE_DS3 : cra_pkg::RATE_STS1;

	always_comb begin
		b_on = pll_mode && (out_sel == cra_pkg::OUT_B || out_sel == cra_pkg::OUT_BOTH);
		c_on = pll_mode && (out_sel == cra_pkg::OUT_C || out_sel == cra_pkg::OUT_BOTH);
		b_rate = (out_sel == cra_pkg::OUT_BOTH) ? other_r : first_r;
		c_rate = (out_sel == cra_pkg::OUT_BOTH) ? first_r : other_r;
	end

	assign g_adapt = !gcfg_q.ext_ref_input_select && !gcfg_q.global_ref_source[cra_pkg::GSRC_PORT_BIT]
		&& gcfg_q.global_ref_source != cra_pkg::GSRC_OFF;
	assign g_rate = gcfg_q.global_ref_source[1:0] - cra_pkg::RATE_CODE_OFS;

	always_comb begin
		pll_need = '0;
		for (int r = 0; r < cra_pkg::NRATE; r++) begin
			if ((b_on && b_rate == 2'(r)) || (c_on && c_rate == 2'(r))) begin
				pll_need[r] = 1'b1;
			end
			if (g_adapt && g_rate == 2'(r)) begin
				pll_need[r] = 1'b1;
			end
			for (int p = 0; p < cra_pkg::NPORT; p++) begin
				if ((pcfg_q[p].line_mode_bits[cra_pkg::LM_LIU_EN] || pcfg_q[p].tx_clock_from_adapter)
					&& port_rate[p] == 2'(r)) begin
					pll_need[r] = 1'b1;
				end
			end
		end
	end

	always_comb begin
		pll_en_d = '0;
		for (int r = 0; r < cra_pkg::NRATE; r++) begin
			pll_en_d[r] = pll_mode && src != 2'(r) && pll_need[r];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pll_en_q <= '0;
		end else begin
			pll_en_q <= pll_en_d;
		end
	end

	// Fractional synthesiser: a backlog of output edges drains one per cycle
	for (genvar r = 0; r < cra_pkg::NRATE; r++) begin : g_syn
		assign gen[r] = acc_q[r] >= cra_pkg::ACC_UNIT;
		always_ff @(posedge ref_clk) begin
			if (rst || !pll_en_d[r]) begin
				acc_q[r] <= 18'h0_0000;
			end else begin
				acc_q[r] <= acc_q[r] + (pin_edge[cra_pkg::SY_A] ? cra_pkg::PLL_INC[src][r] : 18'h0_0000)
					- (gen[r] ? cra_pkg::ACC_UNIT : 18'h0_0000);
			end
		end
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				tog_q[r] <= 1'b0;
			end else if (gen[r]) begin
				tog_q[r] <= !tog_q[r];
			end
		end
		assign rate_tick[r] = pll_mode ? ((src == 2'(r)) ? pin_edge[cra_pkg::SY_A] : gen[r])
			: pin_edge[r];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_b_q <= 1'b0;
			pin_c_q <= 1'b0;
		end else begin
			pin_b_q <= b_on && tog_q[b_rate];
			pin_c_q <= c_on && tog_q[c_rate];
		end
	end

	assign second_ref_pin_o = pin_b_q;
	assign third_ref_pin_o = pin_c_q;
	assign second_ref_pin_oe = pll_mode;
	assign third_ref_pin_oe = pll_mode;
	assign pll_enable = pll_en_q;

	for (genvar p = 0; p < cra_pkg::NPORT; p++) begin : g_port
		logic p_en;
		logic p_tick;
		logic p_rise;
		assign port_rate[p] = cra_pkg::fm_rate(pcfg_q[p].framing_mode_bits);
		assign tx_pick[p] = pcfg_q[p].tx_clock_from_adapter ? rate_tick[port_rate[p]]
			: pin_edge[cra_pkg::SY_TX + p];
		assign port_chg[p] = port_cfg[p] != pcfg_q[p];
		assign p_en = pcfg_q[p].port_ref_source[cra_pkg::PSRC_DIV_BIT];
		assign p_tick = (pcfg_q[p].port_ref_source == cra_pkg::PSRC_TXFR) ? tx_pick[p]
			: pin_edge[cra_pkg::SY_RX + p];
		cra_divider u_pdiv (
			.ref_clk(ref_clk),
			.rst(rst),
			.restart(port_chg[p]),
			.enable(p_en),
			.tick(p_tick),
			.divisor(cra_pkg::rate_div(port_rate[p])),
			.level(),
			.rise(p_rise)
		);
		assign port8k[p] = p_en ? p_rise : rx_plcp_8k[p];
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				liu_q[p] <= 1'b0;
				txc_q[p] <= 1'b0;
				plcp_q[p] <= 1'b0;
			end else begin
				liu_q[p] <= rate_tick[port_rate[p]];
				txc_q[p] <= tx_pick[p];
				plcp_q[p] <= pcfg_q[p].tx_plcp_ref_select ? port8k[p] : g8k_q;
			end
		end
	end

	assign liu_ref_tick = liu_q;
	assign tx_clk_tick = txc_q;
	assign tx_plcp_frame_ref = plcp_q;

	assign g_chg = glob_cfg != gcfg_q;
	assign g_en = gcfg_q.ext_ref_input_select || gcfg_q.global_ref_source != cra_pkg::GSRC_OFF;

	cra_divider u_gdiv (
		.ref_clk(ref_clk),
		.rst(rst),
		.restart(g_chg),
		.enable(g_adapt),
		.tick(rate_tick[g_rate]),
		.divisor(cra_pkg::rate_div(g_rate)),
		.level(),
		.rise(g_rise)
	);

	always_comb begin
		if (gcfg_q.ext_ref_input_select) begin
			g8k_d = pin_edge[cra_pkg::SY_G4];
		end else if (gcfg_q.global_ref_source[cra_pkg::GSRC_PORT_BIT]) begin
			g8k_d = port8k[gcfg_q.global_ref_source[1:0]];
		end else begin
			g8k_d = g_adapt && g_rise;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			g8k_q <= 1'b0;
			pin2_q <= 1'b0;
		end else begin
			g8k_q <= g8k_d;
			pin2_q <= g8k_d && gcfg_q.ref_output_select;
		end
	end

	assign frame_ref_8khz = g8k_q;
	assign general_pin_two_o = pin2_q;
	assign general_pin_two_oe = gcfg_q.ref_output_select;

	cra_divider u_sdiv (
		.ref_clk(ref_clk),
		.rst(rst),
		.restart(g_chg),
		.enable(g_en),
		.tick(g8k_q),
		.divisor(cra_pkg::DIV_SEC),
		.level(one_second_ref),
		.rise(sec_rise)
	);

	// A rise in the clearing cycle keeps the flag set
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= sec_rise || (flag_q && !second_flag_clear);
		end
	end

	assign latched_second_flag = flag_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_gsrc_off;
		(gcfg_q.global_ref_source == cra_pkg::GSRC_OFF && !gcfg_q.ext_ref_input_select) [*2];
	endsequence

	sequence s_ext_edge;
		gcfg_q.ext_ref_input_select && pin_edge[cra_pkg::SY_G4];
	endsequence

	a_bypass_inputs: assert property ((glob_cfg.rate_adapter_mode[3:2] == cra_pkg::MODE_BYPASS)
		|=> (!second_ref_pin_oe && !third_ref_pin_oe) ##1 (pll_enable == 3'h0))
		else $error("Bypass mode left a pin driven or a synthesiser on");
	a_src_no_pll: assert property (pll_mode |=> !pll_enable[$past(src)])
		else $error("Synthesiser enabled for the supplied rate");
	a_pins_low: assert property ((pll_mode && out_sel == cra_pkg::OUT_NONE)
		|=> (!second_ref_pin_o && !third_ref_pin_o))
		else $error("Pin B or C not low in no-output mode");
	a_both_rates: assert property ((pll_mode && out_sel == cra_pkg::OUT_BOTH)
		|=> ((pll_enable | (3'h1 << $past(src))) == cra_pkg::ALL_RATES))
		else $error("Both-output mode missing a synthesised rate");
	a_pll_need: assert property ((pll_enable & ~$past(pll_need)) == 3'h0)
		else $error("Synthesiser running without a consumer");
	a_tx_adapter: assert property ((pcfg_q[0].tx_clock_from_adapter && rate_tick[port_rate[0]])
		|=> tx_clk_tick[0])
		else $error("Adapter edge not passed to transmit clock");
	a_ext_ref: assert property (s_ext_edge |=> frame_ref_8khz)
		else $error("External 8 kHz edge not passed to global reference");
	a_global_off: assert property (s_gsrc_off |=> (!frame_ref_8khz && !one_second_ref))
		else $error("Global reference active while deselected");
	a_plcp_global: assert property ((!pcfg_q[0].tx_plcp_ref_select && g8k_q)
		|=> tx_plcp_frame_ref[0])
		else $error("Global 8 kHz not pacing transmit PLCP");
	a_flag_set: assert property (sec_rise |=> latched_second_flag)
		else $error("One-second rise did not set latched flag");
endmodule
`default_nettype wire

//--- cra_osc_model.sv
// Reference oscillator model that feeds the three adapter clock pins
`timescale 1ns/1ns
`default_nettype none
module cra_osc_model (
	input wire logic ref_clk, // System clock
	input wire logic run, // Oscillator running
	input wire logic b_o, // Pin B drive from block
	input wire logic b_oe, // Pin B driven by block
	input wire logic c_o, // Pin C drive from block
	input wire logic c_oe, // Pin C driven by block
	output logic pin_a, // Pin A level
	output logic pin_b, // Pin B wire level
	output logic pin_c, // Pin C wire level
	output var int n_rise // Rising edges sent on pin A
);
	logic osc = 1'b0;
	initial n_rise = 0;
	// Stopped oscillator rests low; fastest rate the 2-flop sync can follow
	always @(negedge ref_clk) begin
		osc <= run ? ~osc : 1'b0;
		if (run && !osc) begin
			n_rise <= n_rise + 1;
		end
	end
	// A pin that the block drives carries its drive, else the oscillator
	assign pin_a = osc;
	assign pin_b = b_oe ? b_o : osc;
	assign pin_c = c_oe ? c_o : osc;
endmodule
`default_nettype wire

//--- clock_rate_adapter_8k_reference_tb.sv
// Self-checking bench for the clock rate adapter and 8 kHz reference block
`timescale 1ns/1ns
`default_nettype none
module clock_rate_adapter_8k_reference_tb;
	logic ref_clk, rst, run, flag_clr, pin_four;
	cra_pkg::cra_glob_cfg_s gcfg;
	cra_pkg::cra_port_cfg_s [3:0] pcfg;
	logic [3:0] plcp, liu_t, txc_t, txf;
	logic pin_a, pin_b, pin_c, b_o, b_oe, c_o, c_oe, two_o, two_oe, f8k, sec, sflag;
	logic [2:0] pll;
	logic sec_d = 1'b0;
	logic b_d = 1'b0;
	logic c_d = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] act_v, e_v;
	logic [31:0] rnd = 32'h17b7_dad4;
	logic [12:0] dv[3] = '{cra_pkg::DIV_DS3, cra_pkg::DIV_E3, cra_pkg::DIV_STS1};
	event got;
	int n_rise, err_total = 0, n_compared = 0;
	int n_frame = 0, n_two = 0, last_a = 0, period_a = 0, sec_at = 0, rb = 0, rc = 0;
	int n_liu = 0, n_txc = 0;
	int n_tx[4] = '{0, 0, 0, 0};
	int tx0[4];

	cra_clock_ref cra_clock_ref_i (.ref_clk(ref_clk), .rst(rst), .glob_cfg(gcfg),
		.port_cfg(pcfg), .primary_ref_pin_i(pin_a), .second_ref_pin_i(pin_b),
		.second_ref_pin_o(b_o), .second_ref_pin_oe(b_oe), .third_ref_pin_i(pin_c),
		.third_ref_pin_o(c_o), .third_ref_pin_oe(c_oe), .tx_clk_pin({4{pin_a}}),
		.rx_line_clk({4{pin_a}}), .rx_plcp_8k(plcp), .general_pin_four_i(pin_four),
		.general_pin_two_o(two_o), .general_pin_two_oe(two_oe),
		.second_flag_clear(flag_clr), .pll_enable(pll), .liu_ref_tick(liu_t),
		.tx_clk_tick(txc_t), .tx_plcp_frame_ref(txf), .frame_ref_8khz(f8k),
		.one_second_ref(sec), .latched_second_flag(sflag));
	cra_osc_model cra_osc_model_i (.ref_clk(ref_clk), .run(run), .b_o(b_o), .b_oe(b_oe),
		.c_o(c_o), .c_oe(c_oe), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c), .n_rise(n_rise));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Pin A edges between two frame pulses give the divisor, free of latency
	always @(posedge ref_clk) begin
		sec_d <= sec;
		b_d <= b_o;
		c_d <= c_o;
		if (f8k === 1'b1) begin
			n_frame <= n_frame + 1;
			period_a <= n_rise - last_a;
			last_a <= n_rise;
		end
		if (two_oe === 1'b1 && two_o === 1'b1) n_two <= n_two + 1;
		if (b_o === 1'b1 && b_d === 1'b0) rb <= rb + 1;
		if (c_o === 1'b1 && c_d === 1'b0) rc <= rc + 1;
		if (liu_t[0] === 1'b1) n_liu <= n_liu + 1;
		if (txc_t[1] === 1'b1) n_txc <= n_txc + 1;
		for (int i = 0; i < 4; i++) begin
			if (txf[i] === 1'b1) n_tx[i] <= n_tx[i] + 1;
		end
		if (sec === 1'b1 && sec_d === 1'b0) sec_at <= n_frame;
	end

	initial forever begin
		@(got);
		e_v = exp_q.pop_front();
		n_compared++;
		if (act_v !== e_v) begin
			err_total++;
			$display("Error at %0t: expected %h got %h", $time, e_v, act_v);
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Synthesised edge count within one edge of the ideal rate ratio
	function automatic logic near(input int cnt, input int n, input longint num, input longint den);
		return (cnt * den <= n * num + den) && (cnt * den + den >= n * num);
	endfunction

	// Expected {B oe, C oe, synthesiser enables} when no port needs a rate
	function automatic logic [4:0] mode_exp(input logic [3:0] m);
		logic [1:0] s, f, o;
		logic [2:0] p;
		if (m[3:2] == 2'h0) return 5'h00;
		s = m[3:2] - 2'h1;
		f = (s == cra_pkg::RATE_E3) ? cra_pkg::RATE_DS3 : cra_pkg::RATE_E3;
		o = (s == cra_pkg::RATE_STS1) ? cra_pkg::RATE_DS3 : cra_pkg::RATE_STS1;
		p = 3'h0;
		if (m[0]) p[m[1] ? o : f] = 1'b1;
		if (m[1]) p[m[0] ? f : o] = 1'b1;
		return {2'h3, p};
	endfunction

	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		act_v = a;
		->got;
		#1;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic pulse(input int p, input int w);
		plcp[p] = 1'b1;
		cyc(1);
		plcp[p] = 1'b0;
		cyc(w);
	endtask

	task automatic wait_frames(input int n);
		int s;
		s = n_frame;
		for (int k = 0; k < 40000 && n_frame < s + n; k++) @(negedge ref_clk);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		// Four divider measurements of 1.5 periods each at two cycles a tick plus 4000 paced frames fit well inside
		#(100000 * 50);
		err_total++;
		report_and_stop();
	end

	initial begin
		int s0, s1, w;
		rst = 1'b1;
		run = 1'b0;
		flag_clr = 1'b0;
		pin_four = 1'b0;
		plcp = 4'h0;
		gcfg = '0;
		pcfg = '0;
		repeat (16) @(negedge ref_clk);
		chk(32'({b_oe, c_oe, pll, f8k, sec}), 32'h0000_0000);
		rst = 1'b0;
		cyc(3);
		chk(32'({b_oe, c_oe, pll}), 32'h0000_0000);
		done("reset");
		for (int m = 0; m < 16; m++) begin
			gcfg.rate_adapter_mode = 4'(m);
			cyc(4);
			chk(32'({b_oe, c_oe, pll}), 32'(mode_exp(4'(m))));
		end
		// A port using the supplied rate needs no synthesiser
		gcfg.rate_adapter_mode = 4'h4;
		pcfg[0].line_mode_bits = 3'h1;
		cyc(4);
		chk(32'(pll), 32'h0000_0000);
		pcfg[0].framing_mode_bits = 6'h10;
		cyc(4);
		chk(32'(pll), 32'h0000_0002);
		pcfg[1].tx_clock_from_adapter = 1'b1;
		pcfg[1].framing_mode_bits = 6'h20;
		cyc(4);
		chk(32'(pll), 32'h0000_0006);
		// DS3 on pin A: port 1 line reference at E3, port 2 transmit clock at STS-1
		s0 = n_rise;
		s1 = n_liu;
		w = n_txc;
		run = 1'b1;
		cyc(400);
		run = 1'b0;
		cyc(8);
		chk(32'(near(n_liu - s1, n_rise - s0, cra_pkg::KHZ_E3, cra_pkg::KHZ_DS3)), 32'h0000_0001);
		chk(32'(near(n_txc - w, n_rise - s0, cra_pkg::KHZ_STS1, cra_pkg::KHZ_DS3)), 32'h0000_0001);
		pcfg = '0;
		run = 1'b1;
		s0 = rb;
		cyc(400);
		chk(32'(rb - s0), 32'h0000_0000);
		gcfg.rate_adapter_mode = 4'h7;
		cyc(4);
		s0 = rb;
		s1 = rc;
		cyc(400);
		chk(32'(rb - s0 > rc - s1 && rc > s1), 32'h0000_0001);
		done("adapter");
		gcfg = '0;
		gcfg.ref_output_select = 1'b1;
		cyc(4);
		s0 = n_frame;
		s1 = n_two;
		for (int r = 0; r < 3; r++) begin
			gcfg.global_ref_source = 3'(r + 1);
			wait_frames(2);
			chk(32'(period_a), 32'(dv[r]));
		end
		cyc(4);
		chk(32'(n_two - s1), 32'(n_frame - s0));
		// Port 1 paced by its transmit clock pin at the E3 divisor
		pcfg[0].framing_mode_bits = 6'h10;
		pcfg[0].port_ref_source = 2'h3;
		gcfg.global_ref_source = 3'h4;
		wait_frames(2);
		chk(32'(period_a), 32'(cra_pkg::DIV_E3));
		pcfg = '0;
		run = 1'b0;
		done("divider");
		for (int p = 0; p < 4; p++) begin
			gcfg.global_ref_source = 3'(4 + p);
			for (int i = 0; i < 4; i++) begin
				pcfg[i].tx_plcp_ref_select = (i == (p + 2) % 4);
			end
			cyc(4);
			s0 = n_frame;
			tx0 = n_tx;
			pulse(p, 5);
			pulse((p + 1) % 4, 5);
			chk(32'(n_frame - s0), 32'h0000_0001);
			for (int i = 0; i < 4; i++) begin
				chk(32'(n_tx[i] - tx0[i]), 32'(i != (p + 2) % 4));
			end
		end
		gcfg.global_ref_source = 3'h0;
		gcfg.ext_ref_input_select = 1'b1;
		cyc(4);
		s0 = n_frame;
		repeat (5) begin
			pin_four = 1'b1;
			cyc(3);
			pin_four = 1'b0;
			cyc(3);
		end
		cyc(4);
		chk(32'(n_frame - s0), 32'h0000_0005);
		done("select");
		gcfg.ext_ref_input_select = 1'b0;
		gcfg.global_ref_source = 3'h4;
		pcfg = '0;
		cyc(4);
		chk(32'(sflag), 32'h0000_0000);
		s0 = n_frame;
		s1 = sec_at;
		for (int k = 0; k < 9000 && sec_at == s1; k++) begin
			rnd = xs(rnd);
			w = 3 + int'(rnd[1:0]);
			pulse(0, w);
		end
		cyc(2);
		chk(32'(sec_at - s0), 32'(cra_pkg::DIV_SEC / 2));
		chk(32'({sec, sflag}), 32'h0000_0003);
		flag_clr = 1'b1;
		cyc(2);
		flag_clr = 1'b0;
		cyc(2);
		chk(32'(sflag), 32'h0000_0000);
		done("one_second");
		report_and_stop();
	end
endmodule
`default_nettype wire
